// file: rtl/tmr_params.svh
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH
// Register addresses on the special function register port.
`define TMR_ADDR_CTL 8'h88
`define TMR_ADDR_MODE 8'h89
`define TMR_ADDR_T0L 8'h8A
`define TMR_ADDR_T1L 8'h8B
`define TMR_ADDR_T0H 8'h8C
`define TMR_ADDR_T1H 8'h8D
`define TMR_ADDR_CKDIV 8'h8E
`define TMR_ADDR_T2CTL 8'hC8
`define TMR_ADDR_CAPL 8'hCA
`define TMR_ADDR_CAPH 8'hCB
`define TMR_ADDR_T2L 8'hCC
`define TMR_ADDR_T2H 8'hCD
// Reset values.
`define TMR_RST_BYTE 8'h00
`define TMR_RST_CKDIV 3'h0
// Field positions.
`define TMR_CKDIV_LSB 3
`define TMR_CKDIV_MSB 5
`define TMR_MODE_SPLIT 2'h3
`define TMR_MODE_13 2'h0
`define TMR_MODE_RELOAD8 2'h2
// Pin index in the synchroniser vector.
`define TMR_PIN_T0 0
`define TMR_PIN_T1 1
`define TMR_PIN_T2 2
`define TMR_PIN_TIMER2_EXT_TRIGGER_PIN 3
`define TMR_PIN_EXT_IRQ0_PIN 4
`define TMR_PIN_EXT_IRQ1_PIN 5
`define TMR_PIN_N 6
// Prescaler: one tick every twelve system clocks.
`define TMR_DIV12_LAST 4'hB
`endif

// file: rtl/tmr_pkg.sv
package tmr_pkg;
    // Timer 2 operating mode, Gray coded along off, capture, reload, baud.
    typedef enum logic [1:0] {
        TMR_T2_OFF = 2'h0,
        TMR_T2_CAPTURE = 2'h1,
        TMR_T2_RELOAD = 2'h3,
        TMR_T2_BAUD = 2'h2
    } tmr_t2_mode_e;
    typedef logic [7:0] tmr_byte_t;
endpackage : tmr_pkg

// file: rtl/tmr_timers.sv
`timescale 1ns/1ps
`include "tmr_params.svh"
// Notes on behaviour
// RULE_01: Overflow sets flag; software or vectoring clears.
// RULE_02: Run bit enables or disables timer.
// RULE_03: Edge flag sticky; level flag mirrors inverted pin.
// RULE_04: Type bit: level low or falling edge.
// RULE_05: Gate bit adds pin-high condition to run.
// RULE_06: Source bit: prescaled tick or pin falls.
// RULE_07: Mode field: 13, 16, 8-reload, split/off.
// RULE_08: Timers 0/1 hold 16 bits, byte access.
// RULE_09: Timer 2 is 16 bits, byte access.
// RULE_10: Timer 2 source: divided clock or pin.
// RULE_11: Timer 2 overflow triggers converter start.
// RULE_12: Timer 2 mode decoded from control bits.
// RULE_13: Trigger fall captures count, sets external flag.
// RULE_14: Captures only while external enable set.
// RULE_15: Capture-mode rollover sets Timer 2 overflow flag.
// RULE_16: Software sets capture, run, enable bits.
// RULE_17: 13-bit mode uses high byte, low five.
// RULE_18: 8-bit mode reloads low from high.
// RULE_19: Split high byte: system tick, Timer 1 flags.
// RULE_20: Divide bit: clock over twelve or undivided.
// RULE_21: Pins sampled; one event per falling edge.
module tmr_timers (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire tmr_pkg::tmr_byte_t sfr_addr,
    input wire logic sfr_wr,
    input wire tmr_pkg::tmr_byte_t sfr_wdata,
    output tmr_pkg::tmr_byte_t sfr_rdata,
    input wire logic timer0_count_pin,
    input wire logic timer1_count_pin,
    input wire logic timer2_count_pin,
    input wire logic timer2_ext_trigger_pin,
    input wire logic ext_irq0_pin,
    input wire logic ext_irq1_pin,
    input wire logic vec_timer0_ack,
    input wire logic vec_timer1_ack,
    input wire logic vec_ext0_ack,
    input wire logic vec_ext1_ack,
    output logic irq_timer0,
    output logic irq_timer1,
    output logic irq_ext0,
    output logic irq_ext1,
    output logic irq_timer2,
    output logic adc_conv_start
);
    import tmr_pkg::*;

    // ------------------------------------------------------------
    // Reset release and pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [`TMR_PIN_N-1:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_lvl_reg;
    logic [`TMR_PIN_N-1:0] pin_raw, pin_agree, pin_lvl_next, pin_fall;

    always_ff @(posedge core_clk or negedge arst_n)
        if (!arst_n)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    assign rst_n = rst_sync_reg[1];

    assign pin_raw = {ext_irq1_pin, ext_irq0_pin, timer2_ext_trigger_pin,
                      timer2_count_pin, timer1_count_pin, timer0_count_pin};
    // A level counts only once two later stages agree, so a glitch caught by one stage is dropped.
    assign pin_agree = ~(pin_s2_reg ^ pin_s3_reg);
    assign pin_lvl_next = (pin_agree & pin_s2_reg) | (~pin_agree & pin_lvl_reg);
    assign pin_fall = pin_lvl_reg & ~pin_lvl_next; // RULE_21

    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n)
        begin
            pin_s1_reg <= '1;
            pin_s2_reg <= '1;
            pin_s3_reg <= '1;
            pin_lvl_reg <= '1;
        end
        else
        begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pin_lvl_reg <= pin_lvl_next;
        end

    // ------------------------------------------------------------
    // Register write decode and prescaler
    // ------------------------------------------------------------
    tmr_byte_t timer_control_status_reg, timer_mode_select_reg, timer2_control_reg;
    tmr_byte_t tl0_reg, th0_reg, tl1_reg, th1_reg, tl2_reg, th2_reg, cap_lo_reg, cap_hi_reg;
    logic [2:0] ckdiv_reg;
    logic [3:0] div_reg;
    logic tick12, tick0, tick1, tick2;
    logic wr_ctl, wr_mode, wr_t0l, wr_t0h, wr_t1l, wr_t1h, wr_ckdiv;
    logic wr_t2ctl, wr_capl, wr_caph, wr_t2l, wr_t2h;

    assign wr_ctl = sfr_wr && sfr_addr == `TMR_ADDR_CTL;
    assign wr_mode = sfr_wr && sfr_addr == `TMR_ADDR_MODE;
    assign wr_t0l = sfr_wr && sfr_addr == `TMR_ADDR_T0L;
    assign wr_t0h = sfr_wr && sfr_addr == `TMR_ADDR_T0H;
    assign wr_t1l = sfr_wr && sfr_addr == `TMR_ADDR_T1L;
    assign wr_t1h = sfr_wr && sfr_addr == `TMR_ADDR_T1H;
    assign wr_ckdiv = sfr_wr && sfr_addr == `TMR_ADDR_CKDIV;
    assign wr_t2ctl = sfr_wr && sfr_addr == `TMR_ADDR_T2CTL;
    assign wr_capl = sfr_wr && sfr_addr == `TMR_ADDR_CAPL;
    assign wr_caph = sfr_wr && sfr_addr == `TMR_ADDR_CAPH;
    assign wr_t2l = sfr_wr && sfr_addr == `TMR_ADDR_T2L;
    assign wr_t2h = sfr_wr && sfr_addr == `TMR_ADDR_T2H;

    assign tick12 = div_reg == `TMR_DIV12_LAST;
    assign tick0 = ckdiv_reg[0] | tick12; // RULE_20
    assign tick1 = ckdiv_reg[1] | tick12; // RULE_20
    assign tick2 = ckdiv_reg[2] | tick12; // RULE_20

    // ------------------------------------------------------------
    // Timers 0 and 1
    // ------------------------------------------------------------
    // Returns {overflow, high, low} for one step of modes 0 to 3.
    function automatic logic [16:0] tmr_step(input logic [1:0] mode, input tmr_byte_t hi,
                                             input tmr_byte_t lo, input logic inc);
        logic [13:0] c13;
        logic [16:0] c16;
        logic [8:0] c8;
        begin
            c13 = {1'b0, hi, lo[4:0]} + 14'h1;
            c16 = {1'b0, hi, lo} + 17'h1;
            c8 = {1'b0, lo} + 9'h1;
            if (!inc)
                tmr_step = {1'b0, hi, lo};
            else
                case (mode)
                    2'h0: tmr_step = {c13[13], c13[12:5], lo[7:5], c13[4:0]}; // RULE_17
                    2'h1: tmr_step = c16;
                    2'h2: tmr_step = {c8[8], hi, c8[8] ? hi : c8[7:0]}; // RULE_18
                    default: tmr_step = {c8[8], hi, c8[7:0]};
                endcase
        end
    endfunction : tmr_step

    logic tf1, tr1, tf0, tr0, ie1, it1, ie0, it0;
    logic [1:0] t0_mode, t1_mode;
    logic t0_split, run0, run1, inc0, inc1, th0_inc, tf0_set, tf1_set;
    logic [16:0] step0, step1;
    logic [8:0] th0_sum;

    assign {tf1, tr1, tf0, tr0, ie1, it1, ie0, it0} = timer_control_status_reg;
    assign t0_mode = timer_mode_select_reg[1:0]; // RULE_07
    assign t1_mode = timer_mode_select_reg[5:4]; // RULE_07
    assign t0_split = t0_mode == `TMR_MODE_SPLIT;
    assign run0 = tr0 && (!timer_mode_select_reg[3] || pin_lvl_reg[`TMR_PIN_EXT_IRQ0_PIN]); // RULE_02 RULE_05
    assign run1 = tr1 && (!timer_mode_select_reg[7] || pin_lvl_reg[`TMR_PIN_EXT_IRQ1_PIN]); // RULE_02 RULE_05
    assign inc0 = run0 && (timer_mode_select_reg[2] ? pin_fall[`TMR_PIN_T0] : tick0); // RULE_06
    // Timer 1 is idle in its own split mode and loses its pin while Timer 0 is split.
    assign inc1 = run1 && t1_mode != `TMR_MODE_SPLIT && // RULE_07
                  ((timer_mode_select_reg[6] && !t0_split) ? pin_fall[`TMR_PIN_T1] : tick1); // RULE_06
    assign step0 = tmr_step(t0_mode, th0_reg, tl0_reg, inc0);
    assign step1 = tmr_step(t1_mode, th1_reg, tl1_reg, inc1);
    assign th0_inc = t0_split && tr1 && tick0; // RULE_19
    assign th0_sum = {1'b0, th0_reg} + 9'h1;
    assign tf0_set = step0[16]; // RULE_01
    assign tf1_set = t0_split ? (th0_inc && th0_sum[8]) : step1[16]; // RULE_19

    // ------------------------------------------------------------
    // Control register with flags; a hardware set beats any clear
    // ------------------------------------------------------------
    logic ie0_next, ie1_next;
    tmr_byte_t ctl_wv, ctl_next;

    assign ctl_wv = wr_ctl ? sfr_wdata : timer_control_status_reg;
    assign ie0_next = it0 ? ((ctl_wv[1] && !vec_ext0_ack) || pin_fall[`TMR_PIN_EXT_IRQ0_PIN]) // RULE_03 RULE_04
                          : !pin_lvl_next[`TMR_PIN_EXT_IRQ0_PIN]; // RULE_03
    assign ie1_next = it1 ? ((ctl_wv[3] && !vec_ext1_ack) || pin_fall[`TMR_PIN_EXT_IRQ1_PIN]) // RULE_03 RULE_04
                          : !pin_lvl_next[`TMR_PIN_EXT_IRQ1_PIN]; // RULE_03
    assign ctl_next = {(ctl_wv[7] && !vec_timer1_ack) || tf1_set, ctl_wv[6], // RULE_01
                       (ctl_wv[5] && !vec_timer0_ack) || tf0_set, ctl_wv[4], // RULE_01
                       ie1_next, ctl_wv[2], ie0_next, ctl_wv[0]};

    // ------------------------------------------------------------
    // Timer 2
    // ------------------------------------------------------------
    tmr_t2_mode_e t2_mode;
    logic tr2, timer2_ext_enable, inc2, t2_ovf, t2_reload, ext_evt, cap_evt, tf2_set;
    logic [15:0] cnt2, cnt2_hw;
    tmr_byte_t t2ctl_wv, t2ctl_next;

    assign tr2 = timer2_control_reg[2];
    assign timer2_ext_enable = timer2_control_reg[3];
    assign t2_mode = !tr2 ? TMR_T2_OFF : // RULE_12
                     (timer2_control_reg[5] || timer2_control_reg[4]) ? TMR_T2_BAUD : // RULE_12
                     timer2_control_reg[0] ? TMR_T2_CAPTURE : TMR_T2_RELOAD; // RULE_12
    assign cnt2 = {th2_reg, tl2_reg}; // RULE_09
    // The baud timebase is not modelled; baud mode counts like auto-reload without setting the overflow flag.
    assign inc2 = tr2 && (timer2_control_reg[1] ? pin_fall[`TMR_PIN_T2] : tick2); // RULE_10
    assign t2_ovf = inc2 && cnt2 == 16'hFFFF;
    assign t2_reload = t2_mode == TMR_T2_RELOAD || t2_mode == TMR_T2_BAUD;
    assign ext_evt = pin_fall[`TMR_PIN_TIMER2_EXT_TRIGGER_PIN] && timer2_ext_enable && t2_mode != TMR_T2_OFF; // RULE_14
    assign cap_evt = ext_evt && t2_mode == TMR_T2_CAPTURE; // RULE_13
    assign tf2_set = t2_ovf && (t2_mode == TMR_T2_CAPTURE || t2_mode == TMR_T2_RELOAD); // RULE_15
    assign cnt2_hw = ((ext_evt || t2_ovf) && t2_reload) ? {cap_hi_reg, cap_lo_reg} :
                     inc2 ? cnt2 + 16'h1 : cnt2;
    assign t2ctl_wv = wr_t2ctl ? sfr_wdata : timer2_control_reg;
    assign t2ctl_next = {t2ctl_wv[7] || tf2_set, t2ctl_wv[6] || ext_evt, t2ctl_wv[5:0]}; // RULE_13 RULE_15

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n)
        begin
            div_reg <= 4'h0;
            ckdiv_reg <= `TMR_RST_CKDIV;
            timer_control_status_reg <= `TMR_RST_BYTE;
            timer_mode_select_reg <= `TMR_RST_BYTE;
            timer2_control_reg <= `TMR_RST_BYTE;
            tl0_reg <= `TMR_RST_BYTE;
            th0_reg <= `TMR_RST_BYTE;
            tl1_reg <= `TMR_RST_BYTE;
            th1_reg <= `TMR_RST_BYTE;
            tl2_reg <= `TMR_RST_BYTE;
            th2_reg <= `TMR_RST_BYTE;
            cap_lo_reg <= `TMR_RST_BYTE;
            cap_hi_reg <= `TMR_RST_BYTE;
            adc_conv_start <= 1'b0;
            irq_timer2 <= 1'b0;
        end
        else
        begin
            div_reg <= tick12 ? 4'h0 : div_reg + 4'h1;
            ckdiv_reg <= wr_ckdiv ? sfr_wdata[`TMR_CKDIV_MSB:`TMR_CKDIV_LSB] : ckdiv_reg;
            timer_control_status_reg <= ctl_next;
            timer_mode_select_reg <= wr_mode ? sfr_wdata : timer_mode_select_reg;
            timer2_control_reg <= t2ctl_next;
            tl0_reg <= wr_t0l ? sfr_wdata : step0[7:0]; // RULE_08
            th0_reg <= wr_t0h ? sfr_wdata : th0_inc ? th0_sum[7:0] : step0[15:8]; // RULE_08 RULE_19
            tl1_reg <= wr_t1l ? sfr_wdata : step1[7:0]; // RULE_08
            th1_reg <= wr_t1h ? sfr_wdata : step1[15:8]; // RULE_08
            tl2_reg <= wr_t2l ? sfr_wdata : cnt2_hw[7:0]; // RULE_09
            th2_reg <= wr_t2h ? sfr_wdata : cnt2_hw[15:8]; // RULE_09
            cap_lo_reg <= wr_capl ? sfr_wdata : cap_evt ? tl2_reg : cap_lo_reg; // RULE_13
            cap_hi_reg <= wr_caph ? sfr_wdata : cap_evt ? th2_reg : cap_hi_reg; // RULE_13
            adc_conv_start <= t2_ovf; // RULE_11
            irq_timer2 <= t2ctl_next[7] | t2ctl_next[6]; // RULE_13 RULE_15
        end

    // ------------------------------------------------------------
    // Read port and interrupt lines
    // ------------------------------------------------------------
    tmr_byte_t rd_mux;

    assign rd_mux = sfr_addr == `TMR_ADDR_CTL ? timer_control_status_reg :
                    sfr_addr == `TMR_ADDR_MODE ? timer_mode_select_reg :
                    sfr_addr == `TMR_ADDR_T0L ? tl0_reg :
                    sfr_addr == `TMR_ADDR_T1L ? tl1_reg :
                    sfr_addr == `TMR_ADDR_T0H ? th0_reg :
                    sfr_addr == `TMR_ADDR_T1H ? th1_reg :
                    sfr_addr == `TMR_ADDR_CKDIV ? {2'h0, ckdiv_reg, 3'h0} :
                    sfr_addr == `TMR_ADDR_T2CTL ? timer2_control_reg :
                    sfr_addr == `TMR_ADDR_CAPL ? cap_lo_reg :
                    sfr_addr == `TMR_ADDR_CAPH ? cap_hi_reg :
                    sfr_addr == `TMR_ADDR_T2L ? tl2_reg :
                    sfr_addr == `TMR_ADDR_T2H ? th2_reg : 8'h00;

    always_ff @(posedge core_clk or negedge rst_n)
        if (!rst_n)
            sfr_rdata <= 8'h00;
        else
            sfr_rdata <= rd_mux;

    // Timer 0, Timer 1 and external interrupt lines are the flag flip-flops themselves; enables live in the core.
    assign irq_timer0 = tf0;
    assign irq_timer1 = tf1;
    assign irq_ext0 = ie0;
    assign irq_ext1 = ie1;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    property p_tf0_set;
        tf0_set && !vec_timer0_ack |=> tf0;
    endproperty
    a_tf0_set: assert property (p_tf0_set) else $error("overflow flag 0 not set"); // RULE_01
    property p_tf0_ack;
        vec_timer0_ack && !tf0_set |=> !tf0;
    endproperty
    a_tf0_ack: assert property (p_tf0_ack) else $error("overflow flag 0 kept after vector"); // RULE_01
    property p_run_gate;
        (!tr0 || (timer_mode_select_reg[3] && !pin_lvl_reg[`TMR_PIN_EXT_IRQ0_PIN])) && !t0_split
            && !wr_t0l && !wr_t0h |=> $stable(tl0_reg) && $stable(th0_reg);
    endproperty
    a_run_gate: assert property (p_run_gate) else $error("timer 0 moved while stopped"); // RULE_05
    property p_lvl_irq;
        !it0 |=> ie0 == !pin_lvl_reg[`TMR_PIN_EXT_IRQ0_PIN];
    endproperty
    a_lvl_irq: assert property (p_lvl_irq) else $error("level flag not inverse of pin"); // RULE_03
    property p_edge_irq;
        it0 && pin_fall[`TMR_PIN_EXT_IRQ0_PIN] |=> ie0;
    endproperty
    a_edge_irq: assert property (p_edge_irq) else $error("edge flag missed"); // RULE_04
    property p_reload8;
        t0_mode == `TMR_MODE_RELOAD8 && inc0 && tl0_reg == 8'hFF && !wr_t0l && !wr_t0h
            |=> tl0_reg == $past(th0_reg) && tf0;
    endproperty
    a_reload8: assert property (p_reload8) else $error("8-bit reload wrong"); // RULE_18
    property p_roll13;
        t0_mode == `TMR_MODE_13 && inc0 && th0_reg == 8'hFF && tl0_reg[4:0] == 5'h1F
            && !wr_t0l && !wr_t0h && !vec_timer0_ack |=> th0_reg == 8'h00 && tl0_reg[4:0] == 5'h00 && tf0;
    endproperty
    a_roll13: assert property (p_roll13) else $error("13-bit rollover wrong"); // RULE_17
    property p_capture;
        cap_evt && !wr_capl && !wr_caph |=> {cap_hi_reg, cap_lo_reg} == $past(cnt2) && timer2_control_reg[6];
    endproperty
    a_capture: assert property (p_capture) else $error("capture wrong"); // RULE_13
    property p_no_ext;
        !timer2_ext_enable && !timer2_control_reg[6] && !wr_t2ctl |=> !timer2_control_reg[6];
    endproperty
    a_no_ext: assert property (p_no_ext) else $error("external flag without enable"); // RULE_14
    property p_tf2;
        t2_ovf && t2_mode == TMR_T2_CAPTURE && !wr_t2l && !wr_t2h
            |=> timer2_control_reg[7] && cnt2 == 16'h0000 ##0 adc_conv_start;
    endproperty
    a_tf2: assert property (p_tf2) else $error("timer 2 overflow missed"); // RULE_15
    property p_div12;
        tick12 |=> (!tick12)[*8] ##1 (!tick12)[*3] ##1 tick12;
    endproperty
    a_div12: assert property (p_div12) else $error("prescaler period not twelve"); // RULE_20
    property p_one_fall;
        pin_fall[`TMR_PIN_T0] |=> !pin_fall[`TMR_PIN_T0];
    endproperty
    a_one_fall: assert property (p_one_fall) else $error("double edge event"); // RULE_21

    c_split: cover property (t0_split && tf1_set);
    c_capture: cover property (cap_evt);
    c_edge: cover property (it1 && pin_fall[`TMR_PIN_EXT_IRQ1_PIN]);
endmodule : tmr_timers

// file: sim/tmr_core_model.sv
`timescale 1ns/1ps
`include "tmr_params.svh"
// ----------------------------------------
// Core and pin model
// ----------------------------------------
module tmr_core_model (
    input wire logic core_clk,
    input wire tmr_pkg::tmr_byte_t sfr_rdata,
    output tmr_pkg::tmr_byte_t sfr_addr,
    output logic sfr_wr,
    output tmr_pkg::tmr_byte_t sfr_wdata,
    output logic [`TMR_PIN_N-1:0] pins,
    output logic [3:0] acks
);
    import tmr_pkg::*;

    initial
    begin
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        pins = '1;
        acks = 4'h0;
    end

    task automatic wr(input tmr_byte_t a, input tmr_byte_t d);
        @(posedge core_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
        @(negedge core_clk);
    endtask : wr

    // Read data is registered, so it is taken one edge after the address.
    task automatic rd(input tmr_byte_t a, output tmr_byte_t d);
        @(posedge core_clk);
        sfr_addr <= a;
        @(posedge core_clk);
        @(negedge core_clk);
        d = sfr_rdata;
    endtask : rd

    task automatic pin(input int idx, input logic v);
        @(posedge core_clk);
        pins[idx] <= v;
    endtask : pin

    // Each level is held four cycles, twice what sampling needs, so no edge is lost.
    task automatic fall(input int idx);
        pin(idx, 1'b0);
        repeat (4) @(posedge core_clk);
        pins[idx] <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask : fall

    task automatic ack(input int idx);
        @(posedge core_clk);
        acks[idx] <= 1'b1;
        @(posedge core_clk);
        acks[idx] <= 1'b0;
        @(negedge core_clk);
    endtask : ack
endmodule : tmr_core_model

// file: sim/timer01_ctl_timer2_capture_tb.sv
`timescale 1ns/1ps
`include "tmr_params.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module timer01_ctl_timer2_capture_tb;
    import tmr_pkg::*;
    localparam int CYC_MAX = 20000;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    tmr_byte_t sfr_addr;
    logic sfr_wr;
    tmr_byte_t sfr_wdata;
    tmr_byte_t sfr_rdata;
    logic [`TMR_PIN_N-1:0] pins;
    logic [3:0] acks;
    logic irq_t0, irq_t1, irq_e0, irq_e1, irq_t2, adc;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    int adc_cnt = 0;
    tmr_byte_t v;
    tmr_byte_t w;

    always #2.5 core_clk = ~core_clk;

    tmr_core_model core (.core_clk(core_clk), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .pins(pins), .acks(acks));

    tmr_timers dut (.core_clk(core_clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer0_count_pin(pins[`TMR_PIN_T0]),
        .timer1_count_pin(pins[`TMR_PIN_T1]), .timer2_count_pin(pins[`TMR_PIN_T2]),
        .timer2_ext_trigger_pin(pins[`TMR_PIN_TIMER2_EXT_TRIGGER_PIN]), .ext_irq0_pin(pins[`TMR_PIN_EXT_IRQ0_PIN]),
        .ext_irq1_pin(pins[`TMR_PIN_EXT_IRQ1_PIN]), .vec_timer0_ack(acks[0]), .vec_timer1_ack(acks[1]),
        .vec_ext0_ack(acks[2]), .vec_ext1_ack(acks[3]), .irq_timer0(irq_t0), .irq_timer1(irq_t1),
        .irq_ext0(irq_e0), .irq_ext1(irq_e1), .irq_timer2(irq_t2), .adc_conv_start(adc));

    // ----------------------------------------
    // Closing report and hang guard
    // ----------------------------------------
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
        begin
            $display("Run complete: PASS");
        end
        else
        begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    always @(posedge core_clk)
    begin
        cyc++;
        if (adc === 1'b1)
        begin
            adc_cnt++;
        end
        if (cyc == CYC_MAX)
        begin
            error_cnt++;
            test_done();
        end
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        tmr_byte_t a[13] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'hC8, 8'hCA, 8'hCB, 8'hCC,
            8'hCD, 8'h00};
        for (int i = 0; i < 13; i++)
        begin
            core.rd(a[i], v);
            `CHK("reset value", 8'h00, v)
        end
    endtask : t_reset

    // Overflow in each count mode, then split and inactive Timer 1.
    task automatic t_modes();
        tmr_byte_t lo[3] = '{8'h1E, 8'hFE, 8'hFE};
        tmr_byte_t hi[3] = '{8'hFF, 8'hFF, 8'h80};
        tmr_byte_t hx[3] = '{8'h00, 8'h00, 8'h80};
        core.wr(`TMR_ADDR_CKDIV, 8'h38);
        for (int i = 0; i < 3; i++)
        begin
            core.wr(`TMR_ADDR_CTL, 8'h00);
            core.wr(`TMR_ADDR_MODE, tmr_byte_t'(i));
            core.wr(`TMR_ADDR_T0L, lo[i]);
            core.wr(`TMR_ADDR_T0H, hi[i]);
            core.wr(`TMR_ADDR_CTL, 8'h10);
            repeat (6) @(posedge core_clk);
            `CHK("timer0 flag", 1'b1, irq_t0)
            core.rd(`TMR_ADDR_T0H, v);
            `CHK("timer0 high", hx[i], v)
        end
        core.ack(0);
        `CHK("timer0 flag acked", 1'b0, irq_t0)
        core.wr(`TMR_ADDR_CTL, 8'h00);
        core.rd(`TMR_ADDR_T0L, v);
        repeat (10) @(posedge core_clk);
        core.rd(`TMR_ADDR_T0L, w);
        `CHK("timer0 stopped", v, w)
        core.wr(`TMR_ADDR_MODE, 8'h03);
        core.wr(`TMR_ADDR_T0H, 8'hFE);
        core.wr(`TMR_ADDR_CTL, 8'h40);
        repeat (6) @(posedge core_clk);
        `CHK("split high flag", 1'b1, irq_t1)
        core.wr(`TMR_ADDR_CTL, 8'h00);
        core.wr(`TMR_ADDR_MODE, 8'h30);
        core.wr(`TMR_ADDR_T1L, 8'hFE);
        core.wr(`TMR_ADDR_T1H, 8'hFF);
        core.wr(`TMR_ADDR_CTL, 8'h40);
        repeat (6) @(posedge core_clk);
        `CHK("timer1 inactive", 1'b0, irq_t1)
    endtask : t_modes

    task automatic t_gate_pins();
        core.wr(`TMR_ADDR_CTL, 8'h00);
        core.pin(`TMR_PIN_EXT_IRQ0_PIN, 1'b0);
        core.wr(`TMR_ADDR_MODE, 8'h09);
        core.wr(`TMR_ADDR_T0L, 8'h00);
        core.wr(`TMR_ADDR_CTL, 8'h10);
        repeat (20) @(posedge core_clk);
        `CHK("level ext0 flag", 1'b1, irq_e0)
        core.rd(`TMR_ADDR_T0L, v);
        `CHK("gated count", 8'h00, v)
        core.pin(`TMR_PIN_EXT_IRQ0_PIN, 1'b1);
        repeat (20) @(posedge core_clk);
        `CHK("level ext0 released", 1'b0, irq_e0)
        core.rd(`TMR_ADDR_T0L, v);
        `CHK("gate open counts", 1'b1, v != 8'h00)
        core.wr(`TMR_ADDR_CTL, 8'h04);
        core.fall(`TMR_PIN_EXT_IRQ1_PIN);
        `CHK("edge ext1 flag", 1'b1, irq_e1)
        core.ack(3);
        `CHK("edge ext1 acked", 1'b0, irq_e1)
        core.fall(`TMR_PIN_EXT_IRQ1_PIN);
        core.wr(`TMR_ADDR_CTL, 8'h04);
        `CHK("edge ext1 cleared", 1'b0, irq_e1)
        core.wr(`TMR_ADDR_CTL, 8'h00);
        core.wr(`TMR_ADDR_MODE, 8'h05);
        core.wr(`TMR_ADDR_T0L, 8'h00);
        core.wr(`TMR_ADDR_CTL, 8'h10);
        for (int i = 0; i < 3; i++)
        begin
            core.fall(`TMR_PIN_T0);
        end
        core.rd(`TMR_ADDR_T0L, v);
        `CHK("pin falls counted", 8'h03, v)
        core.wr(`TMR_ADDR_CTL, 8'h00);
        core.wr(`TMR_ADDR_CKDIV, 8'h00);
        core.wr(`TMR_ADDR_MODE, 8'h01);
        core.wr(`TMR_ADDR_T0L, 8'h00);
        core.wr(`TMR_ADDR_CTL, 8'h10);
        repeat (120) @(posedge core_clk);
        core.wr(`TMR_ADDR_CTL, 8'h00);
        core.rd(`TMR_ADDR_T0L, v);
        `CHK("divide by twelve", 1'b1, v >= 8'h09 && v <= 8'h0B)
    endtask : t_gate_pins

    // Timer 2 counts its pin so that captured values are exact.
    task automatic t_t2();
        core.wr(`TMR_ADDR_T2L, 8'h34);
        core.wr(`TMR_ADDR_T2H, 8'h12);
        core.wr(`TMR_ADDR_T2CTL, 8'h0F);
        core.fall(`TMR_PIN_TIMER2_EXT_TRIGGER_PIN);
        core.rd(`TMR_ADDR_CAPL, v);
        `CHK("capture low", 8'h34, v)
        core.rd(`TMR_ADDR_CAPH, v);
        `CHK("capture high", 8'h12, v)
        `CHK("timer2 irq", 1'b1, irq_t2)
        core.rd(`TMR_ADDR_T2CTL, v);
        `CHK("ext flag", 8'h4F, v)
        core.wr(`TMR_ADDR_T2CTL, 8'h07);
        core.wr(`TMR_ADDR_T2L, 8'h56);
        core.fall(`TMR_PIN_TIMER2_EXT_TRIGGER_PIN);
        core.rd(`TMR_ADDR_CAPL, v);
        `CHK("capture held", 8'h34, v)
        `CHK("timer2 irq quiet", 1'b0, irq_t2)
        core.wr(`TMR_ADDR_T2L, 8'hFF);
        core.wr(`TMR_ADDR_T2H, 8'hFF);
        core.fall(`TMR_PIN_T2);
        core.rd(`TMR_ADDR_T2CTL, v);
        `CHK("overflow flag", 8'h87, v)
        core.rd(`TMR_ADDR_T2L, v);
        `CHK("rolled count", 8'h00, v)
        `CHK("conversion starts", 1, adc_cnt)
        core.wr(`TMR_ADDR_T2CTL, 8'h17);
        core.wr(`TMR_ADDR_T2L, 8'hFF);
        core.wr(`TMR_ADDR_T2H, 8'hFF);
        core.fall(`TMR_PIN_T2);
        core.rd(`TMR_ADDR_T2CTL, v);
        `CHK("baud no flag", 8'h17, v)
        core.wr(`TMR_ADDR_T2CTL, 8'h06);
        core.wr(`TMR_ADDR_T2L, 8'hFF);
        core.wr(`TMR_ADDR_T2H, 8'hFF);
        core.fall(`TMR_PIN_T2);
        core.rd(`TMR_ADDR_T2CTL, v);
        `CHK("reload flag", 8'h86, v)
        core.rd(`TMR_ADDR_T2L, v);
        `CHK("reload low", 8'h34, v)
        core.wr(`TMR_ADDR_T2CTL, 8'h03);
        core.wr(`TMR_ADDR_T2L, 8'h05);
        core.fall(`TMR_PIN_T2);
        core.rd(`TMR_ADDR_T2L, v);
        `CHK("timer2 off", 8'h05, v)
    endtask : t_t2

    initial
    begin
        repeat (10) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_reset();
        t_modes();
        t_gate_pins();
        t_t2();
        test_done();
    end
endmodule : timer01_ctl_timer2_capture_tb
